// *** core/asio_core.sv ***
// Supervisor I/O core: power sequencing, relay outputs, link port control,
// shift-chain scanning, analogue select stepping and fan PWM, with AXI4-Lite registers.
// Assumes all pin inputs are asynchronous to aclk and the chain is driven by this block.
`timescale 1ns/10ps
`default_nettype none
module asio_core
   import asio_pkg::*;
#(
   parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        aux_supply_good_in,
   input  wire logic        main_supply_good_in,
   input  wire logic        link_present_in,
   input  wire logic        link_rx_in_port,
   input  wire logic        link_rx_out_port,
   input  wire logic        link_off_switch,
   input  wire logic        chain_miso,
   output var  logic        fault_relay_out,
   output var  logic        power_on_relay_out,
   output var  logic        link_port_swap,
   output var  logic        link_disable_n,
   output var  logic        comm_led_ctl,
   output var  logic        global_mute_n,
   output var  logic        psu_start_ctl,
   output var  logic [2:0]  analog_input_select,
   output var  logic        lower_board_select_n,
   output var  logic        upper_board_select_n,
   output var  logic        chain_sclk,
   output var  logic        chain_mosi,
   output var  logic        fan_speed_ctl
);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Map one board's chain word onto four channel slots of a flag vector.
   function automatic logic [3:0] pick_flag(input logic [31:0] word, input int pos);
      logic [3:0] res;
      res = 4'h0;
      for (int c = 0; c < 4; c++) begin
         res[c] = word[c*CH_STRIDE + pos];
      end
      return res;
   endfunction

   // Fan PWM high time out of 256 slots; the slope never quite reaches the full 256
   // at 40 degrees, so the hard step below 40 is kept separate.
   function automatic logic [8:0] fan_high(input logic [7:0] temp);
      logic [8:0] res;
      if (temp < TEMP_IDLE_DEG) begin
         res = FAN_FULL_HIGH;
      end else if (temp > TEMP_MAX_DEG) begin
         res = 9'h000;
      end else begin
         res = 9'((TEMP_MAX_DEG - temp) * FAN_STEP);
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   asio_pins_type meta_q;
   asio_pins_type pins;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         pins   <= '0;
      end else begin
         meta_q <= '{aux_good: aux_supply_good_in, main_good: main_supply_good_in,
                     present: link_present_in, rx_in: link_rx_in_port,
                     rx_out: link_rx_out_port, link_off: link_off_switch, miso: chain_miso};
         pins   <= meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers written by software.

   logic [31:0]    ctrl;
   logic [7:0]     temp;
   logic [31:0]    out_lower;
   logic [31:0]    out_upper;
   logic [31:0]    in_lower;
   logic [31:0]    in_upper;
   asio_flags_type flags;
   logic [7:0]     wr_addr;
   logic [31:0]    wr_data;
   logic [3:0]     wr_strb;
   logic           aw_full;
   logic           w_full;
   logic           wr_go;

   assign wr_go = aw_full && w_full && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= '0;
         temp      <= '0;
         out_lower <= '0;
         out_upper <= '0;
      end else if (wr_go) begin
         case (wr_addr)
            ADDR_CTRL:      ctrl      <= apply_strb(ctrl, wr_data, wr_strb);
            ADDR_TEMP:      temp      <= wr_strb[0] ? wr_data[7:0] : temp;
            ADDR_OUT_LOWER: out_lower <= apply_strb(out_lower, wr_data, wr_strb);
            ADDR_OUT_UPPER: out_upper <= apply_strb(out_upper, wr_data, wr_strb);
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         wr_addr       <= '0;
         wr_data       <= '0;
         wr_strb       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr       <= s_axi_awaddr;
            aw_full       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            w_full       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_addr)
               ADDR_CTRL, ADDR_TEMP, ADDR_OUT_LOWER, ADDR_OUT_UPPER,
               ADDR_STATUS, ADDR_IN_LOWER, ADDR_IN_UPPER, ADDR_FLAGS: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.

   asio_power_type power_state;
   logic [31:0]    rd_value;
   logic           rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ADDR_CTRL:      rd_value = ctrl;
         ADDR_STATUS:    rd_value = {19'h0, link_port_swap, pins.present, pins.link_off,
                                     pins.main_good, pins.aux_good, 4'(power_state), 4'h0};
         ADDR_TEMP:      rd_value = {24'h0, temp};
         ADDR_OUT_LOWER: rd_value = out_lower;
         ADDR_OUT_UPPER: rd_value = out_upper;
         ADDR_IN_LOWER:  rd_value = in_lower;
         ADDR_IN_UPPER:  rd_value = in_upper;
         ADDR_FLAGS:     rd_value = flags;
         default: begin
            rd_value = '0;
            rd_hit   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_value;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power sequencing.

   logic [23:0] settle_cnt;
   logic        power_req;

   assign power_req = ctrl[CTRL_POWER_REQ];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_state <= PS_STANDBY;
         settle_cnt  <= '0;
      end else begin
         case (power_state)
            PS_STANDBY: begin
               settle_cnt <= '0;
               if (power_req && pins.aux_good) begin
                  power_state <= PS_START;
               end
            end
            PS_START: begin
               if (!power_req || !pins.aux_good) begin
                  power_state <= PS_STANDBY;
               end else if (pins.main_good) begin
                  power_state <= PS_SETTLE;
               end
            end
            PS_SETTLE: begin
               settle_cnt <= settle_cnt + 24'h000001;
               if (!power_req || !pins.main_good) begin
                  power_state <= PS_STANDBY;
               end else if (settle_cnt == 24'(SETTLE_COUNT - 1)) begin
                  power_state <= PS_OPERATE;
               end
            end
            PS_OPERATE: begin
               if (!power_req || !pins.main_good || !pins.aux_good) begin
                  power_state <= PS_STANDBY;
               end
            end
            default: power_state <= PS_STANDBY;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psu_start_ctl      <= 1'b0;
         global_mute_n      <= 1'b0;
         power_on_relay_out <= 1'b0;
         fault_relay_out    <= 1'b0;
      end else begin
         psu_start_ctl      <= (power_state != PS_STANDBY) && power_req;
         global_mute_n      <= (power_state == PS_OPERATE) && power_req && !ctrl[CTRL_MUTE];
         power_on_relay_out <= pins.main_good;
         fault_relay_out    <= |flags.fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link port control.

   logic [15:0] link_win;
   logic        seen_in;
   logic        seen_out;
   logic        prev_in;
   logic        prev_out;

   // Activity is judged over a fixed window so a single stray edge on the
   // in port cannot keep the ports from swapping for long.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_win       <= '0;
         seen_in        <= 1'b0;
         seen_out       <= 1'b0;
         prev_in        <= 1'b0;
         prev_out       <= 1'b0;
         link_port_swap <= 1'b0;
      end else begin
         prev_in  <= pins.rx_in;
         prev_out <= pins.rx_out;
         if (link_win == 16'(LINK_WINDOW_CYCLES - 1)) begin
            link_win <= '0;
            // An edge in the closing cycle opens the next window instead of being lost.
            seen_in  <= (pins.rx_in != prev_in);
            seen_out <= (pins.rx_out != prev_out);
            if (seen_out && !seen_in) begin
               link_port_swap <= !link_port_swap;
            end
         end else begin
            link_win <= link_win + 16'h0001;
            if (pins.rx_in != prev_in) begin
               seen_in <= 1'b1;
            end
            if (pins.rx_out != prev_out) begin
               seen_out <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_disable_n <= 1'b0;
         comm_led_ctl   <= 1'b0;
      end else begin
         link_disable_n <= pins.link_off;
         comm_led_ctl   <= pins.present;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shift chain scanning.

   asio_scan_type scan_state;
   logic [7:0]    div_cnt;
   logic [5:0]    bit_cnt;
   logic          board_upper;
   logic [31:0]   shift_in;
   logic [31:0]   shift_out;
   logic          operate;

   assign operate = (power_state == PS_OPERATE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_state           <= SC_IDLE;
         div_cnt              <= '0;
         bit_cnt              <= '0;
         board_upper          <= 1'b0;
         shift_in             <= '0;
         shift_out            <= '0;
         chain_sclk           <= 1'b0;
         chain_mosi           <= 1'b0;
         lower_board_select_n <= 1'b1;
         upper_board_select_n <= 1'b1;
         in_lower             <= '0;
         in_upper             <= '0;
      end else begin
         case (scan_state)
            SC_IDLE: begin
               chain_sclk <= 1'b0;
               div_cnt    <= '0;
               bit_cnt    <= '0;
               if (operate) begin
                  shift_out            <= board_upper ? out_upper : out_lower;
                  chain_mosi           <= board_upper ? out_upper[CHAIN_BITS-1] : out_lower[CHAIN_BITS-1];
                  lower_board_select_n <= board_upper;
                  upper_board_select_n <= !board_upper;
                  scan_state           <= SC_SHIFT;
               end
            end
            SC_SHIFT: begin
               if (div_cnt == SCLK_HALF_CYCLES - 8'h01) begin
                  div_cnt    <= '0;
                  chain_sclk <= !chain_sclk;
                  if (!chain_sclk) begin
                     shift_in <= {shift_in[CHAIN_BITS-2:0], pins.miso};
                     bit_cnt  <= bit_cnt + 6'h01;
                  end else if (bit_cnt == 6'(CHAIN_BITS)) begin
                     scan_state <= SC_GAP;
                  end else begin
                     shift_out  <= {shift_out[CHAIN_BITS-2:0], 1'b0};
                     chain_mosi <= shift_out[CHAIN_BITS-2];
                  end
               end else begin
                  div_cnt <= div_cnt + 8'h01;
               end
            end
            SC_GAP: begin
               // Raising the select latches the bits shifted out into the chain.
               lower_board_select_n <= 1'b1;
               upper_board_select_n <= 1'b1;
               if (div_cnt == 8'h00) begin
                  if (board_upper) begin
                     in_upper <= shift_in;
                  end else begin
                     in_lower <= shift_in;
                  end
               end
               if (div_cnt == SCLK_HALF_CYCLES - 8'h01) begin
                  div_cnt     <= '0;
                  board_upper <= !board_upper;
                  scan_state  <= SC_IDLE;
               end else begin
                  div_cnt <= div_cnt + 8'h01;
               end
            end
            default: scan_state <= SC_IDLE;
         endcase
      end
   end

   // Flags are cleared outside operate mode so a stale fault cannot hold the relay.
   always_ff @(posedge aclk) begin
      if (!aresetn || !operate) begin
         flags <= '0;
      end else begin
         flags.clip  <= {pick_flag(in_upper, FLAG_CLIP), pick_flag(in_lower, FLAG_CLIP)};
         flags.ilim  <= {pick_flag(in_upper, FLAG_ILIM), pick_flag(in_lower, FLAG_ILIM)};
         flags.avg   <= {pick_flag(in_upper, FLAG_AVG), pick_flag(in_lower, FLAG_AVG)};
         flags.fault <= {pick_flag(in_upper, FLAG_FAULT), pick_flag(in_lower, FLAG_FAULT)};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analogue select stepping and fan control.

   logic [7:0] adc_dwell;
   logic [7:0] pwm_cnt;
   logic [8:0] fan_level;

   always_ff @(posedge aclk) begin
      if (!aresetn || !operate) begin
         adc_dwell           <= '0;
         analog_input_select <= '0;
      end else if (adc_dwell == 8'(ADC_DWELL_CYCLES - 1)) begin
         adc_dwell           <= '0;
         analog_input_select <= analog_input_select + 3'h1;
      end else begin
         adc_dwell <= adc_dwell + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_cnt       <= '0;
         fan_level     <= FAN_FULL_HIGH;
         fan_speed_ctl <= 1'b1;
      end else begin
         pwm_cnt       <= pwm_cnt + 8'h01;
         fan_level     <= fan_high(temp);
         fan_speed_ctl <= {1'b0, pwm_cnt} < fan_level;
      end
   end

endmodule // asio_core
`default_nettype wire

// *** core/asio_pkg.sv ***
// Constants, register map and types for the amplifier supervisor I/O block.
// Assumes a 20 MHz aclk and a 32-bit AXI4-Lite master on the register side.
package asio_pkg;

   localparam int CLK_HZ             = 20_000_000;
   localparam int SETTLE_TIME_MS     = 600;
   localparam int SETTLE_CYCLES      = CLK_HZ / 1000 * SETTLE_TIME_MS;
   localparam int LINK_WINDOW_US     = 100;
   localparam int LINK_WINDOW_CYCLES = CLK_HZ / 1_000_000 * LINK_WINDOW_US;
   localparam int ADC_DWELL_US       = 4;
   localparam int ADC_DWELL_CYCLES   = CLK_HZ / 1_000_000 * ADC_DWELL_US;

   localparam int         CHAIN_BITS       = 32;
   localparam logic [7:0] SCLK_HALF_CYCLES = 8'h04;
   localparam int         CH_STRIDE        = 8;
   localparam int         FLAG_CLIP        = 0;
   localparam int         FLAG_ILIM        = 1;
   localparam int         FLAG_AVG         = 2;
   localparam int         FLAG_FAULT       = 3;

   localparam logic [7:0] TEMP_IDLE_DEG = 8'h28;
   localparam logic [7:0] TEMP_MAX_DEG  = 8'h3c;
   localparam logic [8:0] FAN_STEP      = 9'h00c;
   localparam logic [8:0] FAN_FULL_HIGH = 9'h100;

   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_TEMP      = 8'h08;
   localparam logic [7:0] ADDR_OUT_LOWER = 8'h0c;
   localparam logic [7:0] ADDR_OUT_UPPER = 8'h10;
   localparam logic [7:0] ADDR_IN_LOWER  = 8'h14;
   localparam logic [7:0] ADDR_IN_UPPER  = 8'h18;
   localparam logic [7:0] ADDR_FLAGS     = 8'h1c;

   localparam int CTRL_POWER_REQ = 0;
   localparam int CTRL_MUTE      = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      PS_STANDBY = 4'h1,
      PS_START   = 4'h2,
      PS_SETTLE  = 4'h4,
      PS_OPERATE = 4'h8
   } asio_power_type;

   typedef enum logic [2:0] {
      SC_IDLE  = 3'h1,
      SC_SHIFT = 3'h2,
      SC_GAP   = 3'h4
   } asio_scan_type;

   typedef struct packed {
      logic [7:0] fault;
      logic [7:0] avg;
      logic [7:0] ilim;
      logic [7:0] clip;
   } asio_flags_type;

   typedef struct packed {
      logic aux_good;
      logic main_good;
      logic present;
      logic rx_in;
      logic rx_out;
      logic link_off;
      logic miso;
   } asio_pins_type;

endpackage

// *** dv/asio_chain_model.sv ***
// Behavioural shift chain of both channel boards.
// Assumes selects and sclk come from the core.
`timescale 1ns/10ps
`default_nettype none
module asio_chain_model (
   input wire logic        lower_board_select_n,
   input wire logic        upper_board_select_n,
   input wire logic        chain_sclk,
   input wire logic        chain_mosi,
   input wire logic [31:0] par_lo,
   input wire logic [31:0] par_hi,
   output var logic        chain_miso,
   output var logic [31:0] out_lo,
   output var logic [31:0] out_hi
);
   logic [31:0] sh = 32'h0;
   logic        shown = 1'b0;
   wire         sel = !(lower_board_select_n && upper_board_select_n);
   ////////////////////////////////////////
   always @(negedge lower_board_select_n) sh = par_lo;
   always @(negedge upper_board_select_n) sh = par_hi;
   always @(posedge chain_sclk) sh = {sh[30:0], chain_mosi};
   always @(posedge lower_board_select_n) out_lo = sh;
   always @(posedge upper_board_select_n) out_hi = sh;
   // An unselected line shows the inverse so a stale bit never passes.
   always @* if (sel) shown = sh[31];
   assign chain_miso = sel ? sh[31] : ~shown;
endmodule // asio_chain_model
`default_nettype wire

// *** dv/asio_properties.sv ***
// Port checks for the supervisor core.
// Assumes aclk with a synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
module asio_properties (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       main_supply_good_in,
   input wire logic       link_off_switch,
   input wire logic       link_present_in,
   input wire logic       power_on_relay_out,
   input wire logic       link_disable_n,
   input wire logic       comm_led_ctl,
   input wire logic       global_mute_n,
   input wire logic       psu_start_ctl,
   input wire logic [2:0] analog_input_select,
   input wire logic       lower_board_select_n,
   input wire logic       upper_board_select_n,
   input wire logic       chain_sclk
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Pin inputs pass two synchroniser stages and one output stage.
   AST_RELAY: assert property (main_supply_good_in[*4] |-> power_on_relay_out)
      else $error("power relay lags supply");
   AST_LDIS: assert property (link_off_switch[*4] |-> link_disable_n)
      else $error("link not disabled");
   AST_LEN: assert property (!link_off_switch[*4] |-> !link_disable_n)
      else $error("link disabled");
   AST_LED: assert property (link_present_in[*4] |-> comm_led_ctl)
      else $error("comm led dark");
   AST_MUTE: assert property (global_mute_n |-> psu_start_ctl)
      else $error("unmuted without supply");
   AST_ONE: assert property (lower_board_select_n || upper_board_select_n)
      else $error("both boards selected");
   AST_SCLK: assert property ($changed(chain_sclk) |-> !(lower_board_select_n && upper_board_select_n))
      else $error("sclk moves unselected");
   AST_END: assert property ($rose(lower_board_select_n) || $rose(upper_board_select_n) |-> !chain_sclk)
      else $error("select rises with sclk high");
   AST_AMUX: assert property ($changed(analog_input_select) && analog_input_select != 3'h0
      |-> analog_input_select == $past(analog_input_select) + 3'h1)
      else $error("analog select skips");
   cover property ($rose(global_mute_n));
   cover property ($fell(lower_board_select_n));
   cover property ($fell(upper_board_select_n));
endmodule // asio_properties
bind asio_core asio_properties chk_u (.*);
`default_nettype wire

// *** dv/tb.sv ***
// Bench for the supervisor core: AXI4-Lite tasks and pin scenarios.
// Assumes the chain model and a settle count of 50.
`timescale 1ns/10ps
`default_nettype none
module tb
   import asio_pkg::*;
;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, tv [3];
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, par_lo, par_hi, out_lo, out_hi, rd, hi, fv [3];
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        aux_supply_good_in, main_supply_good_in, link_present_in, link_rx_in_port, link_rx_out_port;
   logic        link_off_switch, chain_miso, fault_relay_out, power_on_relay_out, link_port_swap, link_disable_n;
   logic        comm_led_ctl, global_mute_n, psu_start_ctl, lower_board_select_n, upper_board_select_n;
   logic        chain_sclk, chain_mosi, fan_speed_ctl;
   logic [2:0]  analog_input_select;
   int          fails, compares;
   asio_core #(.SETTLE_COUNT(50)) dut_u (.*);
   asio_chain_model chain_u (.*);
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            rs = s_axi_bresp;
         end
      end while (s_axi_bready);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end while (s_axi_rready);
   endtask
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      complete_run;
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_wdata, aux_supply_good_in, main_supply_good_in, link_present_in} = '0;
      {link_rx_in_port, link_rx_out_port, link_off_switch, aresetn} = '0;
      s_axi_wstrb = 4'hf;
      par_lo = 32'h0000_0108;
      par_hi = 32'h0004_0002;
      tv = '{8'h1e, 8'h32, 8'h46};
      fv = '{32'h100, 32'h78, 32'h0};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("mute", 0, global_mute_n);
      chk("selects", 3, {lower_board_select_n, upper_board_select_n});
      axr(8'h20, rd, rs);
      chk("unmapped", RESP_SLVERR, rs);
      chk("unmapped data", 0, rd);
      axw(8'h20, 32'h1);
      chk("unmapped wr", RESP_SLVERR, rs);
      link_off_switch <= 1'b1;
      link_present_in <= 1'b1;
      aux_supply_good_in <= 1'b1;
      axw(ADDR_CTRL, 32'h1);
      chk("ctrl resp", RESP_OKAY, rs);
      repeat (5) @(posedge aclk);
      chk("disable", 1, link_disable_n);
      chk("led", 1, comm_led_ctl);
      chk("start", 1, psu_start_ctl);
      main_supply_good_in <= 1'b1;
      repeat (70) @(posedge aclk);
      chk("relay", 1, power_on_relay_out);
      axr(ADDR_STATUS, rd, rs);
      chk("state", 8, rd[7:4]);
      chk("mute", 1, global_mute_n);
      axw(ADDR_CTRL, 32'h3);
      chk("mute bit", 0, global_mute_n);
      axw(ADDR_CTRL, 32'h1);
      axw(ADDR_OUT_LOWER, 32'ha5c3_0f1e);
      axw(ADDR_OUT_UPPER, 32'h3c5a_9617);
      repeat (1500) @(posedge aclk);
      axr(ADDR_IN_LOWER, rd, rs);
      chk("in lower", par_lo, rd);
      axr(ADDR_IN_UPPER, rd, rs);
      chk("in upper", par_hi, rd);
      axr(ADDR_FLAGS, rd, rs);
      chk("flags", 32'h0140_1002, rd);
      chk("fault", 1, fault_relay_out);
      chk("out lower", 32'ha5c3_0f1e, out_lo);
      chk("out upper", 32'h3c5a_9617, out_hi);
      foreach (tv[i]) begin
         axw(ADDR_TEMP, {24'h0, tv[i]});
         repeat (300) @(posedge aclk);
         hi = 0;
         repeat (256) @(posedge aclk) hi = hi + fan_speed_ctl;
         chk("fan", fv[i], hi);
      end
      link_rx_out_port <= 1'b1;
      repeat (4500) @(posedge aclk);
      chk("swap", 1, link_port_swap);
      link_rx_out_port <= 1'b0;
      link_rx_in_port <= 1'b1;
      repeat (4500) @(posedge aclk);
      chk("swap", 1, link_port_swap);
      main_supply_good_in <= 1'b0;
      repeat (10) @(posedge aclk);
      chk("mute", 0, global_mute_n);
      chk("relay", 0, power_on_relay_out);
      chk("amux", 0, analog_input_select);
      complete_run;
   end
endmodule // tb
`default_nettype wire
